/* common/mba_pkg.sv */
/*
 * Shared constants and types for the multiprocessor bus arbitration ends:
 * line counts, the layout of the sampled pin vector, reset values and states.
 * Assumes one system clock that all processors and the host share.
 */
package mba_pkg;

   // ***************************************************************
   // sizes
   // ***************************************************************
   localparam int NUM_LINES = 8;
   localparam int ID_W      = 3;
   localparam int SYNC_W    = 18;

   // ***************************************************************
   // positions inside the sampled pin vector
   // ***************************************************************
   localparam int POS_LINES    = 0;
   localparam int POS_HOST_REQ = 8;
   localparam int POS_BACK_OFF = 9;
   localparam int POS_GRANT    = 10;
   localparam int POS_CORE_PRI = 11;
   localparam int POS_DMA_PRI  = 12;
   localparam int POS_ID       = 13;
   localparam int POS_MASTER   = 16;
   localparam int POS_LOCK     = 17;

   // ***************************************************************
   // reset values and timing counts
   // ***************************************************************
   localparam logic [SYNC_W-1:0]    SYNC_RST  = 18'h3FFFF;
   localparam logic [ID_W-1:0]      OWNER_RST = 3'h0;
   localparam logic [NUM_LINES-1:0] LINE_ONE  = 8'h01;
   localparam logic [1:0]           STRAP_DLY = 2'h2;
   localparam logic [ID_W-1:0]      HOST_ID   = 3'h0;

   // ***************************************************************
   // arbitration states, gray along idle-request-own-grant
   // ***************************************************************
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_REQ  = 2'h1,
      ST_OWN  = 2'h3,
      ST_HGNT = 2'h2
   } mba_state_type;

endpackage

/* common/mba_if.sv */
/*
 * Pin-level carrier between one processor end and the host end.
 * Assumes the bench drives every ext_ signal: the other processors' request
 * lines (high when unused), their host grant, priority pulls and the straps.
 */
interface mba_if;
   import mba_pkg::*;

   logic [NUM_LINES-1:0] bus_request_lines_o;
   logic [NUM_LINES-1:0] bus_request_lines_oe_b;
   logic [NUM_LINES-1:0] ext_bus_request_lines_b;
   logic [NUM_LINES-1:0] bus_request_lines_b;
   logic [ID_W-1:0]      processor_identity;
   logic                 host_request_b;
   logic                 back_off_b;
   logic                 host_grant_o;
   logic                 host_grant_oe_b;
   logic                 ext_host_grant_b;
   logic                 host_grant_b;
   logic                 core_priority_line_o;
   logic                 core_priority_line_oe_b;
   logic                 ext_core_priority_line_b;
   logic                 core_priority_line_b;
   logic                 dma_priority_line_o;
   logic                 dma_priority_line_oe_b;
   logic                 ext_dma_priority_line_b;
   logic                 dma_priority_line_b;
   logic                 master_indicator_o;
   logic                 master_indicator_oe_b;
   logic                 ext_master_strap;
   logic                 master_indicator;
   logic                 lock_indicator_o;
   logic                 lock_indicator_oe_b;
   logic                 ext_lock_strap;
   logic                 lock_indicator;

   // ***************************************************************
   // wire levels from the enables
   // ***************************************************************
   // undriven request lines take the outside level, high when unused
   assign bus_request_lines_b = (bus_request_lines_oe_b & ext_bus_request_lines_b) |
                                (~bus_request_lines_oe_b & bus_request_lines_o);
   assign host_grant_b        = host_grant_oe_b ? ext_host_grant_b : host_grant_o;
   // wired-and open-drain lines
   assign core_priority_line_b = ext_core_priority_line_b &
                                 (core_priority_line_oe_b | core_priority_line_o);
   assign dma_priority_line_b  = ext_dma_priority_line_b &
                                 (dma_priority_line_oe_b | dma_priority_line_o);
   assign master_indicator    = master_indicator_oe_b ? ext_master_strap : master_indicator_o;
   assign lock_indicator      = lock_indicator_oe_b ? ext_lock_strap : lock_indicator_o;

   modport proc (
      output bus_request_lines_o, bus_request_lines_oe_b, host_grant_o, host_grant_oe_b,
             core_priority_line_o, core_priority_line_oe_b, dma_priority_line_o,
             dma_priority_line_oe_b, master_indicator_o, master_indicator_oe_b,
             lock_indicator_o, lock_indicator_oe_b,
      input  bus_request_lines_b, processor_identity, host_request_b, back_off_b,
             host_grant_b, core_priority_line_b, dma_priority_line_b, master_indicator,
             lock_indicator
   );

   modport host (
      output processor_identity, host_request_b, back_off_b,
      input  host_grant_b
   );

endinterface

/* hdl/mba_host_end.sv */
/*
 * Host end: requests the processors' external bus, waits for the grant and
 * may force a back-off; also holds the processor identity straps steady.
 * Assumes the processor end and bench share MCLK_I.
 */
module mba_host_end
   import mba_pkg::*;
#(
   parameter logic [ID_W-1:0] PROC_ID = HOST_ID
)
(
   input  wire logic MCLK_I,
   input  wire logic RST_B_I,
   mba_if.host       BUS,
   input  wire logic HOST_REQ_I,
   input  wire logic BACKOFF_I,
   output logic      GRANTED_O
);

   logic [1:0] grant_sync_ff;
   logic       req_b_ff;
   logic       back_off_b_ff;
   logic       granted_ff;
   wire        grant_seen_w;
   wire        nxt_req_b;
   wire        nxt_back_off_b;

   // ***************************************************************
   // grant sampling and request drive
   // ***************************************************************
   assign grant_seen_w = ~grant_sync_ff[1];
   assign nxt_req_b    = ~HOST_REQ_I;
   // back-off only while the bus is still wanted and not yet granted
   assign nxt_back_off_b   = ~(BACKOFF_I & HOST_REQ_I & ~granted_ff);

   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         grant_sync_ff <= 2'h3;
         req_b_ff      <= 1'b1;
         back_off_b_ff     <= 1'b1;
         granted_ff    <= 1'b0;
      end else begin
         grant_sync_ff <= {grant_sync_ff[0], BUS.host_grant_b};
         req_b_ff      <= nxt_req_b;
         back_off_b_ff     <= nxt_back_off_b;
         granted_ff    <= HOST_REQ_I & ~req_b_ff & grant_seen_w;
      end
   end

   assign BUS.host_request_b     = req_b_ff;
   assign BUS.back_off_b         = back_off_b_ff;
   assign BUS.processor_identity = PROC_ID;   // constant for the whole run
   assign GRANTED_O              = granted_ff;

endmodule

/* hdl/mba_proc_end.sv */
/*
 * Processor end of the shared-bus arbitration: request line, ownership
 * tracking, host request/grant, back-off, priority lines, indicators.
 * Assumes all pins arrive from outside and are sampled through two flops.
 */

// Contract
// - drive own request line, watch all others
// - identity code picks request line directly
// - arbitration order follows identity value
// - system keeps identity fixed outside reset
// - system holds unused request lines high
// - bus owner asserts master indicator
// - master indicator pin is strap during reset
// - owner drives lock indicator when locked
// - back-off forces release before transaction ends
// - host asserts host request for bus
// - tri-state external bus when releasing
// - keep host grant until host withdraws
// - only owner drives host grant, slaves monitor
// - core priority asserted during core external access
// - master yields background DMA to core priority
// - priority lines are shared open-drain outputs
// - DMA priority asserted during high-priority DMA
// - master yields normal DMA to DMA priority
module mba_proc_end
   import mba_pkg::*;
(
   input  wire logic MCLK_I,
   input  wire logic RST_B_I,
   mba_if.proc       BUS,
   input  wire logic CORE_REQ_I,
   input  wire logic HDMA_REQ_I,
   input  wire logic NDMA_REQ_I,
   input  wire logic XACT_BUSY_I,
   input  wire logic LOCK_REQ_I,
   output logic      BUS_OWNED_O,
   output logic      BUS_OE_B_O,
   output logic      SDRAM_SREF_O,
   output logic      ABORT_O,
   output logic      HOST_OWNS_BUS_O,
   output logic      STRAP_MASTER_O,
   output logic      STRAP_LOCK_O
);

   logic [SYNC_W-1:0] sync1_ff;
   logic [SYNC_W-1:0] sync2_ff;
   logic [1:0]        cap_cnt_ff;
   logic              strap_done_ff;
   logic              strap_master_ff;
   logic              strap_lock_ff;
   logic [ID_W-1:0]   id_ff;
   logic [ID_W-1:0]   owner_ff;
   logic [ID_W-1:0]   nxt_owner;
   mba_state_type     state_ff;
   mba_state_type     nxt_state;
   logic              line_b_ff;
   logic              owned_ff;
   logic              sref_ff;
   logic              abort_ff;
   logic              master_ff;
   logic              lock_ff;
   logic              grant_b_ff;
   logic              core_pri_ff;
   logic              dma_pri_ff;
   logic [1:0]        core_dly_ff;
   logic [1:0]        dma_dly_ff;

   wire [SYNC_W-1:0]    pin_w;
   wire [NUM_LINES-1:0] line_act_w;
   wire [NUM_LINES-1:0] own_sel_w;
   wire                 host_req_w;
   wire                 back_off_w;
   wire                 grant_act_w;
   wire                 other_core_w;
   wire                 other_dma_w;
   wire                 is_owner_w;
   wire                 want_w;
   wire                 yield_w;
   wire                 host_elsewhere_w;
   wire                 hold_line_w;

   // ***************************************************************
   // pin sampling
   // ***************************************************************
   assign pin_w = {BUS.lock_indicator, BUS.master_indicator, BUS.processor_identity,
                   BUS.dma_priority_line_b, BUS.core_priority_line_b, BUS.host_grant_b,
                   BUS.back_off_b, BUS.host_request_b, BUS.bus_request_lines_b};

   // two flops on every pin; request, back-off, grant and priority lines active low
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         sync1_ff <= SYNC_RST;
         sync2_ff <= SYNC_RST;
      end else begin
         sync1_ff <= pin_w;
         sync2_ff <= sync1_ff;
      end
   end

   assign line_act_w  = ~sync2_ff[POS_LINES +: NUM_LINES];
   assign host_req_w  = ~sync2_ff[POS_HOST_REQ];
   assign back_off_w  = ~sync2_ff[POS_BACK_OFF];
   assign grant_act_w = ~sync2_ff[POS_GRANT];

   // ***************************************************************
   // straps caught once the sampler has settled after release
   // ***************************************************************
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         cap_cnt_ff      <= 2'h0;
         strap_done_ff   <= 1'b0;
         strap_master_ff <= 1'b0;
         strap_lock_ff   <= 1'b0;
         id_ff           <= OWNER_RST;
      end else if (!strap_done_ff) begin
         cap_cnt_ff <= cap_cnt_ff + 2'h1;
         if (cap_cnt_ff == STRAP_DLY) begin
            strap_done_ff   <= 1'b1;
            strap_master_ff <= sync2_ff[POS_MASTER];
            strap_lock_ff   <= sync2_ff[POS_LOCK];
            id_ff           <= sync2_ff[POS_ID +: ID_W];
         end
      end
   end

   // ***************************************************************
   // ownership: owner keeps the bus until its line drops, then the
   // lowest asserted identity takes it
   // ***************************************************************
   always_comb begin
      nxt_owner = owner_ff;
      if (!line_act_w[owner_ff] && (line_act_w != '0)) begin
         for (int k = NUM_LINES - 1; k >= 0; k--) begin
            if (line_act_w[k]) begin
               nxt_owner = ID_W'(k);
            end
         end
      end
   end

   assign is_owner_w = strap_done_ff && (owner_ff == id_ff);

   // ***************************************************************
   // priority lines seen from others, own drive masked by its delay
   // ***************************************************************
   assign other_core_w = ~sync2_ff[POS_CORE_PRI] & ~core_dly_ff[1];
   assign other_dma_w  = ~sync2_ff[POS_DMA_PRI] & ~dma_dly_ff[1];
   assign want_w       = CORE_REQ_I | HDMA_REQ_I | NDMA_REQ_I;
   // background and normal DMA give way to a slave's higher class
   assign yield_w      = (other_core_w & ~CORE_REQ_I) |
                         (other_dma_w & ~CORE_REQ_I & ~HDMA_REQ_I);
   // slaves watch the grant driven by the owner
   assign host_elsewhere_w = grant_act_w & ~is_owner_w;

   // ***************************************************************
   // arbitration state
   // ***************************************************************
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (is_owner_w && host_req_w) begin
               nxt_state = ST_HGNT;
            end else if (strap_done_ff && want_w && !yield_w && !host_elsewhere_w) begin
               nxt_state = ST_REQ;
            end
         end
         ST_REQ: begin
            if (!want_w) begin
               nxt_state = ST_IDLE;
            end else if (is_owner_w && host_req_w) begin
               nxt_state = ST_HGNT;
            end else if (is_owner_w) begin
               nxt_state = ST_OWN;
            end
         end
         ST_OWN: begin
            if (back_off_w) begin
               nxt_state = host_req_w ? ST_HGNT : ST_IDLE;
            end else if (host_req_w && !XACT_BUSY_I) begin
               nxt_state = ST_HGNT;
            end else if ((!want_w || yield_w) && !XACT_BUSY_I) begin
               nxt_state = ST_IDLE;
            end
         end
         ST_HGNT: begin
            if (!host_req_w) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   assign hold_line_w = (nxt_state == ST_REQ) || (nxt_state == ST_OWN) ||
                        (nxt_state == ST_HGNT);

   // ***************************************************************
   // registered outputs
   // ***************************************************************
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         state_ff    <= ST_IDLE;
         owner_ff    <= OWNER_RST;
         line_b_ff   <= 1'b1;
         owned_ff    <= 1'b0;
         sref_ff     <= 1'b0;
         abort_ff    <= 1'b0;
         master_ff   <= 1'b0;
         lock_ff     <= 1'b0;
         grant_b_ff  <= 1'b1;
         core_pri_ff <= 1'b0;
         dma_pri_ff  <= 1'b0;
         core_dly_ff <= 2'h0;
         dma_dly_ff  <= 2'h0;
      end else begin
         state_ff    <= nxt_state;
         owner_ff    <= nxt_owner;
         line_b_ff   <= ~hold_line_w;
         owned_ff    <= (nxt_state == ST_OWN);
         sref_ff     <= (nxt_state == ST_HGNT);
         abort_ff    <= (state_ff == ST_OWN) && back_off_w && XACT_BUSY_I;
         master_ff   <= is_owner_w && (nxt_state != ST_HGNT);
         lock_ff     <= is_owner_w && (nxt_state == ST_OWN) && LOCK_REQ_I;
         grant_b_ff  <= (nxt_state != ST_HGNT);
         core_pri_ff <= strap_done_ff && CORE_REQ_I &&
                        ((nxt_state == ST_REQ) || (nxt_state == ST_OWN));
         dma_pri_ff  <= strap_done_ff && HDMA_REQ_I &&
                        ((nxt_state == ST_REQ) || (nxt_state == ST_OWN));
         core_dly_ff <= {core_dly_ff[0], core_pri_ff};
         dma_dly_ff  <= {dma_dly_ff[0], dma_pri_ff};
      end
   end

   // ***************************************************************
   // pin drive
   // ***************************************************************
   assign own_sel_w = strap_done_ff ? (LINE_ONE << id_ff) : '0;
   assign BUS.bus_request_lines_o    = {NUM_LINES{line_b_ff}};
   assign BUS.bus_request_lines_oe_b = ~own_sel_w;
   assign BUS.host_grant_o           = grant_b_ff;
   assign BUS.host_grant_oe_b        = ~is_owner_w;
   assign BUS.core_priority_line_o    = 1'b0;
   assign BUS.core_priority_line_oe_b = ~core_pri_ff;
   assign BUS.dma_priority_line_o     = 1'b0;
   assign BUS.dma_priority_line_oe_b  = ~dma_pri_ff;
   // indicator pins stay released until the straps are caught
   assign BUS.master_indicator_o     = master_ff;
   assign BUS.master_indicator_oe_b  = ~strap_done_ff;
   assign BUS.lock_indicator_o       = lock_ff;
   assign BUS.lock_indicator_oe_b    = ~strap_done_ff;

   assign BUS_OWNED_O     = owned_ff;
   assign BUS_OE_B_O      = ~owned_ff;
   assign SDRAM_SREF_O    = sref_ff;
   assign ABORT_O         = abort_ff;
   assign HOST_OWNS_BUS_O = grant_act_w;
   assign STRAP_MASTER_O  = strap_master_ff;
   assign STRAP_LOCK_O    = strap_lock_ff;

endmodule

/* dv/mba_asserts.sv */
/*
 * Checker for the arbitration pins between processor end and host end.
 * Assumes it sits beside the carrier, on the shared system clock and reset.
 */
module mba_asserts
   import mba_pkg::*;
(
   input  wire logic                 MCLK_I,
   input  wire logic                 RST_B_I,
   input  wire logic [NUM_LINES-1:0] bus_request_lines_oe_b,
   input  wire logic [NUM_LINES-1:0] bus_request_lines_b,
   input  wire logic [ID_W-1:0]      processor_identity,
   input  wire logic                 host_request_b,
   input  wire logic                 back_off_b,
   input  wire logic                 host_grant_b,
   input  wire logic                 core_priority_line_o,
   input  wire logic                 core_priority_line_oe_b,
   input  wire logic                 dma_priority_line_o,
   input  wire logic                 dma_priority_line_oe_b,
   input  wire logic                 master_indicator_oe_b,
   input  wire logic                 master_indicator,
   input  wire logic                 lock_indicator_oe_b,
   input  wire logic                 lock_indicator
);
   timeunit 1ns;
   timeprecision 100ps;

   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (!RST_B_I);

   // ***************************************************************
   // sequences
   // ***************************************************************
   // pins stay released while the straps are captured
   sequence s_strap_hold;
      (master_indicator_oe_b && lock_indicator_oe_b && (&bus_request_lines_oe_b))[*3];
   endsequence

   sequence s_grant_soon;
      ##[1:6] !host_grant_b;
   endsequence

   // ***************************************************************
   // properties
   // ***************************************************************
   a_own_line_only: assert property (bus_request_lines_oe_b != 8'hFF |->
      bus_request_lines_oe_b == ~(LINE_ONE << processor_identity))
      else $error("request line driven other than the one picked by identity");
   a_strap_window: assert property ($rose(RST_B_I) |-> s_strap_hold)
      else $error("indicator or request pin driven during strap capture");
   a_grant_cause: assert property ($fell(host_grant_b) |->
      $past(host_request_b, 3) == 1'b0)
      else $error("host grant without an earlier host request");
   a_grant_hold: assert property (!host_grant_b && !host_request_b |=> !host_grant_b)
      else $error("host grant dropped while the host still requests");
   a_master_off_grant: assert property (!host_grant_b [*2] |-> !master_indicator)
      else $error("master indicator high while the host holds the bus");
   a_lock_by_master: assert property ($rose(lock_indicator) && !lock_indicator_oe_b
      |-> master_indicator)
      else $error("lock indicator raised by a non-master");
   a_core_pull_req: assert property ($fell(core_priority_line_oe_b) |->
      !bus_request_lines_b[processor_identity])
      else $error("core priority pulled without a bus request");
   a_core_open_drain: assert property (!core_priority_line_oe_b |->
      !core_priority_line_o && !bus_request_lines_b[processor_identity])
      else $error("core priority line driven high or pulled without a request");
   a_dma_open_drain: assert property (!dma_priority_line_oe_b |->
      !dma_priority_line_o && !bus_request_lines_b[processor_identity])
      else $error("dma priority line driven high or pulled without a request");
   a_backoff_yield: assert property ($fell(back_off_b) && master_indicator
      && !master_indicator_oe_b |-> s_grant_soon)
      else $error("master kept the bus after back-off");
endmodule

/* dv/mba_tb.sv */
/*
 * Self-checking bench: processor end and host end joined by one carrier.
 * Assumes the bench plays the other processors through the ext_ signals.
 */
module mba_tb;
   import mba_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   localparam logic [ID_W-1:0] MY_ID = 3'h2;
   logic        clk, rst_b, core, hdma, ndma, busy, lock, hreq, back_off;
   logic        owned, oe_b, sref, abort, hown, smas, slock, granted, ms_exp, lk_exp;
   logic [13:0] st;
   logic [27:0] exp_q[$];
   int          failures, n_checks;
   event        note_ev, done_ev;

   mba_if bus_if ();
   mba_proc_end mba_proc_end_inst (.MCLK_I(clk), .RST_B_I(rst_b), .BUS(bus_if),
      .CORE_REQ_I(core), .HDMA_REQ_I(hdma), .NDMA_REQ_I(ndma), .XACT_BUSY_I(busy),
      .LOCK_REQ_I(lock), .BUS_OWNED_O(owned), .BUS_OE_B_O(oe_b), .SDRAM_SREF_O(sref),
      .ABORT_O(abort), .HOST_OWNS_BUS_O(hown), .STRAP_MASTER_O(smas), .STRAP_LOCK_O(slock));
   mba_host_end #(.PROC_ID(MY_ID)) mba_host_end_inst (.MCLK_I(clk), .RST_B_I(rst_b),
      .BUS(bus_if), .HOST_REQ_I(hreq), .BACKOFF_I(back_off), .GRANTED_O(granted));
   mba_asserts mba_asserts_inst (.MCLK_I(clk), .RST_B_I(rst_b),
      .bus_request_lines_oe_b(bus_if.bus_request_lines_oe_b),
      .bus_request_lines_b(bus_if.bus_request_lines_b),
      .processor_identity(bus_if.processor_identity), .host_request_b(bus_if.host_request_b),
      .back_off_b(bus_if.back_off_b), .host_grant_b(bus_if.host_grant_b),
      .core_priority_line_o(bus_if.core_priority_line_o),
      .core_priority_line_oe_b(bus_if.core_priority_line_oe_b),
      .dma_priority_line_o(bus_if.dma_priority_line_o),
      .dma_priority_line_oe_b(bus_if.dma_priority_line_oe_b),
      .master_indicator_oe_b(bus_if.master_indicator_oe_b),
      .master_indicator(bus_if.master_indicator),
      .lock_indicator_oe_b(bus_if.lock_indicator_oe_b), .lock_indicator(bus_if.lock_indicator));

   // status bits: 0 owned, 1 bus oe_b, 2 sref, 3 abort, 4 granted, 5 grant pin,
   // 6 master, 7 lock, 8 core pri, 9 dma pri, 10 own line, 11/12 straps, 13 host seen
   assign st = {hown, slock, smas, bus_if.bus_request_lines_b[MY_ID],
                bus_if.dma_priority_line_b, bus_if.core_priority_line_b, bus_if.lock_indicator,
                bus_if.master_indicator, bus_if.host_grant_b, granted, abort, sref, oe_b, owned};

   // ***************************************************************
   // helpers
   // ***************************************************************
   task automatic wrap_up();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic cyc();
      @(posedge clk);
      #2;
   endtask

   // stimulus waits until the watcher has compared, so no later drive races it
   task automatic chk(input logic [13:0] m, input logic [13:0] v);
      exp_q.push_back({m, v});
      -> note_ev;
      @(done_ev);
   endtask

   task automatic compare_st(input logic [13:0] m, input logic [13:0] v);
      n_checks++;
      if ((st & m) !== v) begin
         failures++;
         $display("MISMATCH %0t status %h expected %h under mask %h", $time, st, v, m);
      end
   endtask

   task automatic wait_st(input int b, input logic v, input int lim);
      for (int i = 0; i < lim; i++) begin
         if (st[b] === v) return;
         cyc();
      end
      failures++;
      $display("MISMATCH %0t status bit %0d never reached %b", $time, b, v);
      wrap_up();
   endtask

   // ***************************************************************
   // clock, monitor, stimulus
   // ***************************************************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial begin
      logic [27:0] e;
      forever begin
         @(note_ev);
         while (exp_q.size() != 0) begin
            e = exp_q.pop_front();
            compare_st(e[27:14], e[13:0]);
         end
         -> done_ev;
      end
   end

   initial begin
      {rst_b, core, hdma, ndma, busy, lock, hreq, back_off} = 8'h00;
      failures = 0;
      n_checks = 0;
      void'($urandom(32'h0166));
      {lk_exp, ms_exp} = 2'($urandom());
      bus_if.ext_master_strap = ms_exp;
      bus_if.ext_lock_strap = lk_exp;
      bus_if.ext_bus_request_lines_b = 8'hFF;
      bus_if.ext_host_grant_b = 1'b1;
      bus_if.ext_core_priority_line_b = 1'b1;
      bus_if.ext_dma_priority_line_b = 1'b1;
      repeat (12) @(posedge clk);
      #2 rst_b = 1'b1;
      repeat (4) cyc();
      chk(14'h3C40, {1'b0, lk_exp, ms_exp, 11'h400});
      $display("done: straps and reset");
      bus_if.ext_bus_request_lines_b = 8'hFD;
      core = 1'b1;
      repeat (8) cyc();
      chk(14'h0441, 14'h0000);
      bus_if.ext_bus_request_lines_b = 8'hFF;
      wait_st(0, 1'b1, 12);
      chk(14'h0543, 14'h0041);
      lock = 1'b1;
      repeat (3) cyc();
      chk(14'h0080, 14'h0080);
      lock = 1'b0;
      $display("done: arbitration order and lock");
      busy = 1'b1;
      hreq = 1'b1;
      repeat (6 + $urandom_range(4, 0)) cyc();
      chk(14'h0021, 14'h0021);
      busy = 1'b0;
      wait_st(5, 1'b0, 10);
      chk(14'h0047, 14'h0006);
      wait_st(4, 1'b1, 10);
      repeat (4) cyc();
      chk(14'h2024, 14'h2004);
      hreq = 1'b0;
      wait_st(5, 1'b1, 10);
      chk(14'h0004, 14'h0000);
      wait_st(0, 1'b1, 12);
      $display("done: host grant");
      busy = 1'b1;
      hreq = 1'b1;
      back_off = 1'b1;
      wait_st(3, 1'b1, 12);
      chk(14'h0009, 14'h0008);
      cyc();
      chk(14'h0008, 14'h0000);
      {busy, back_off, core} = 3'h0;
      wait_st(4, 1'b1, 12);
      hreq = 1'b0;
      wait_st(5, 1'b1, 10);
      repeat (4) cyc();
      $display("done: back-off");
      for (int k = 0; k < 2; k++) begin
         hdma = k[0];
         ndma = !k[0];
         wait_st(0, 1'b1, 12);
         chk(14'h0200, k[0] ? 14'h0000 : 14'h0200);
         if (k == 1) bus_if.ext_core_priority_line_b = 1'b0;
         else bus_if.ext_dma_priority_line_b = 1'b0;
         wait_st(0, 1'b0, 10);
         chk(14'h0001, 14'h0000);
         bus_if.ext_core_priority_line_b = 1'b1;
         bus_if.ext_dma_priority_line_b = 1'b1;
         {hdma, ndma} = 2'h0;
         repeat (4) cyc();
      end
      $display("done: priority yield");
      cyc();
      wrap_up();
   end
endmodule
